// ### hdl/sbcl_top.sv
// How it works
// - chip select high ignores the other command pins; running work carries on.
// - with select low, row/column/write strobes decode the eight commands.
// - legality applies only with clock enable high on this and last edge.
// - idle bank takes activate; device takes refresh or mode load when idle.
// - row active bank takes read, write or precharge.
// - plain read burst takes read, write, terminate; precharge truncates it.
// - plain write burst takes write, read, precharge; controller masks data.
// - precharging lasts the precharge period then bank goes idle.
// - activating lasts the activate-to-access delay then bank is row active.
// - auto precharge access holds the bank until precharge period ends.
// - refresh holds the device for refresh cycle time, then all idle.
// - mode load holds the device for the mode-register delay, then idle.
// - precharge-all holds the device for the precharge period, then idle.
// - burst terminate ends the latest read burst if it is plain, whatever its bank.
// - reads and writes accepted with or without auto precharge.
// - other banks accept row commands while bank n idle, active, or timed.
// - other banks accept row commands during bursts; a write can cut into a read.
// - address bit 10 high on read or write selects auto precharge.
// - address bit 10 high on precharge selects all banks.
// - a high write byte mask blocks that byte from being written.
`timescale 1ns/1ps
`include "sbcl_map.svh"

module sbcl_top
  import sbcl_pkg::*;
#(
  parameter int NBANK = 4,
  parameter int CW = 8,
  parameter int NBYTE = 2,
  parameter int T_RP = `SBCL_PRECHARGE_PERIOD_CYC,
  parameter int T_RCD = `SBCL_ACT_TO_ACCESS_CYC,
  parameter int T_RFC = `SBCL_REFRESH_CYCLE_CYC,
  parameter int T_MRD = `SBCL_MODE_REG_DELAY_CYC,
  parameter int T_BURST = `SBCL_BURST_LEN_CYC
)
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_SRST,
  // command pins
  input wire sbcl_pins_t I_PINS,
  input wire logic I_CKE,
  input wire logic I_EXIT_DONE,
  // write data path
  input wire logic [8*NBYTE-1:0] I_WDATA,
  input wire logic [NBYTE-1:0] I_WRITE_BYTE_MASK,
  input wire logic I_WDATA_VALID,
  // status
  output logic [4*NBANK-1:0] O_BANK_STATE,
  output logic [1:0] O_DEV_STATE,
  output logic O_CMD_ACCEPTED,
  output logic O_CMD_ILLEGAL,
  // masked write to array
  output logic [8*NBYTE-1:0] O_ARRAY_WDATA,
  output logic [NBYTE-1:0] O_ARRAY_BYTE_WE
);

  initial
  begin
    // the bank address is two bits wide, so more than four trackers cannot be reached
    if (NBANK < 2 || NBANK > 4 || CW < 2)
    begin
      $error("sbcl_top: unsupported bank count or counter width");
    end
    // counters load the period less one, so a one-cycle period has no encoding
    if (T_RP < 2 || T_RCD < 2 || T_RFC < 2 || T_MRD < 2 || T_BURST < 2)
    begin
      $error("sbcl_top: timing counts must be at least two cycles");
    end
    if (T_RP > (1 << CW) || T_RCD > (1 << CW) || T_RFC > (1 << CW) || T_MRD > (1 << CW)
        || T_BURST > (1 << CW))
    begin
      $error("sbcl_top: timing count does not fit the counter");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // types and functions

  typedef struct packed {
    sbcl_dev_t dev;
    logic [CW-1:0] cnt;
    logic cke_prev;
    logic [1:0] last_rd_bank;
    logic last_rd_valid;
    logic accepted;
    logic illegal;
    logic [8*NBYTE-1:0] wdata;
    logic [NBYTE-1:0] byte_we;
  } sbcl_top_state_t;

  function automatic sbcl_cmd_t decode_cmd(input sbcl_pins_t p);
    sbcl_cmd_t c;
    c = SBCL_CMD_NOP;
    if (!p.cs_n)
    begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        3'b111: c = SBCL_CMD_NOP;
        3'b011: c = SBCL_CMD_ACT;
        3'b101: c = SBCL_CMD_RD;
        3'b100: c = SBCL_CMD_WR;
        3'b010: c = SBCL_CMD_PRE;
        3'b110: c = SBCL_CMD_BST;
        3'b001: c = SBCL_CMD_REF;
        3'b000: c = SBCL_CMD_LMR;
      endcase
    end
    return c;
  endfunction

  function automatic logic [CW-1:0] to_cnt(input int v);
    return v[CW-1:0];
  endfunction

  // a timed state shows for the period less one cycle, so the follow-up
  // command may be registered exactly one period after the one that started it
  function automatic logic [CW-1:0] to_load(input int v);
    return to_cnt(v - 1);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // decode

  sbcl_top_state_t r;
  sbcl_top_state_t next_r;
  sbcl_dec_t dec;
  sbcl_bank_t bank_st [NBANK];
  logic [NBANK-1:0] bank_illegal;
  logic [NBANK-1:0] bank_hit;
  logic [NBANK-1:0] bank_bst;
  logic legal_en;
  logic all_idle;
  logic dev_busy;
  logic force_idle;
  logic rd_open;

  always_comb
  begin
    dec.cmd = decode_cmd(I_PINS);
    dec.bank = I_PINS.bank;
    dec.auto_pre = I_PINS.addr[`SBCL_AP_BIT];
    dec.all_banks = I_PINS.addr[`SBCL_AP_BIT] && dec.cmd == SBCL_CMD_PRE;
  end

  // exit-delay completion comes from the power logic outside this block
  assign legal_en = r.cke_prev && I_CKE && I_EXIT_DONE;
  assign dev_busy = r.dev != SBCL_D_NORMAL;
  assign force_idle = dev_busy && r.cnt == to_cnt(1);

  always_comb
  begin
    all_idle = 1'b1;
    rd_open = 1'b0;
    for (int b = 0; b < NBANK; b++)
    begin
      if (bank_st[b] != SBCL_B_IDLE)
      begin
        all_idle = 1'b0;
      end
      // terminate only has something to cut while the latest plain read still streams
      if (r.last_rd_valid && r.last_rd_bank == 2'(b) && bank_st[b] == SBCL_B_READ)
      begin
        rd_open = 1'b1;
      end
      // per-bank hit: other banks proceed independently
      bank_hit[b] = !dev_busy && (dec.all_banks || dec.bank == 2'(b));
      bank_bst[b] = legal_en && !dev_busy && dec.cmd == SBCL_CMD_BST && r.last_rd_valid
                    && r.last_rd_bank == 2'(b);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bank trackers

  for (genvar g = 0; g < NBANK; g++)
  begin : g_bank
    sbcl_bank #(
      .CW(CW)
    ) u_bank (
      .i_clk(I_MCLK),
      .i_srst(I_SRST),
      .i_hit(bank_hit[g] && !dec.all_banks),
      .i_legal_en(legal_en),
      .i_dec(dec),
      .i_bst_me(bank_bst[g]),
      .i_force_idle(force_idle),
      .i_t_rp(to_load(T_RP)),
      .i_t_rcd(to_load(T_RCD)),
      .i_t_burst(to_load(T_BURST)),
      .o_state(bank_st[g]),
      .o_illegal(bank_illegal[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // device-wide state

  always_comb
  begin
    next_r = r;
    next_r.cke_prev = I_CKE;
    next_r.accepted = 1'b0;
    next_r.illegal = |bank_illegal;
    next_r.byte_we = '0;
    next_r.wdata = I_WDATA;
    if (I_WDATA_VALID)
    begin
      next_r.byte_we = ~I_WRITE_BYTE_MASK;
    end
    if (dev_busy)
    begin
      // only nop or deselect is expected until the period ends
      next_r.cnt = r.cnt - 1'b1;
      if (r.cnt == to_cnt(1))
      begin
        next_r.dev = SBCL_D_NORMAL;
        next_r.cnt = '0;
      end
      if (legal_en && dec.cmd != SBCL_CMD_NOP)
      begin
        next_r.illegal = 1'b1;
      end
    end
    else if (legal_en)
    begin
      unique case (dec.cmd)
        SBCL_CMD_REF, SBCL_CMD_LMR:
          if (all_idle)
          begin
            next_r.dev = (dec.cmd == SBCL_CMD_REF) ? SBCL_D_REFRESHING : SBCL_D_MODE_ACCESS;
            next_r.cnt = (dec.cmd == SBCL_CMD_REF) ? to_load(T_RFC) : to_load(T_MRD);
            next_r.accepted = 1'b1;
          end
          else
          begin
            next_r.illegal = 1'b1;
          end
        SBCL_CMD_PRE:
          if (dec.all_banks)
          begin
            next_r.dev = SBCL_D_PRECHARGE_ALL;
            next_r.cnt = to_load(T_RP);
            next_r.accepted = 1'b1;
            next_r.last_rd_valid = 1'b0;
          end
          else
          begin
            next_r.accepted = 1'b1;
          end
        SBCL_CMD_RD:
        begin
          // a refused read must not become the target of a later terminate
          if (!(|bank_illegal))
          begin
            next_r.last_rd_bank = dec.bank;
            next_r.last_rd_valid = !dec.auto_pre;
          end
          next_r.accepted = 1'b1;
        end
        SBCL_CMD_BST:
        begin
          next_r.accepted = rd_open;
          next_r.illegal = !rd_open;
          next_r.last_rd_valid = 1'b0;
        end
        SBCL_CMD_ACT, SBCL_CMD_WR:
          next_r.accepted = 1'b1;
        default:
        begin
        end
      endcase
    end
    // a bank reporting illegal overrides the accept pulse
    if (|bank_illegal)
    begin
      next_r.accepted = 1'b0;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SRST)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  logic [4*NBANK-1:0] bank_vec;
  always_comb
  begin
    for (int b = 0; b < NBANK; b++)
    begin
      bank_vec[4*b +: 4] = bank_st[b];
    end
  end

  assign O_BANK_STATE = bank_vec;
  assign O_DEV_STATE = r.dev;
  assign O_CMD_ACCEPTED = r.accepted;
  assign O_CMD_ILLEGAL = r.illegal;
  assign O_ARRAY_WDATA = r.wdata;
  assign O_ARRAY_BYTE_WE = r.byte_we;

endmodule

// ### hdl/sbcl_map.svh
`ifndef SBCL_MAP_SVH
`define SBCL_MAP_SVH

// default timing in cycles of the 50 MHz clock
`define SBCL_PERIOD_NS 20
`define SBCL_PRECHARGE_PERIOD_CYC 3
`define SBCL_ACT_TO_ACCESS_CYC 3
`define SBCL_REFRESH_CYCLE_CYC 8
`define SBCL_MODE_REG_DELAY_CYC 2
`define SBCL_BURST_LEN_CYC 4
// address bit that carries auto precharge / precharge all
`define SBCL_AP_BIT 10
`define SBCL_BANK_RESET 4'h0
`define SBCL_DEV_RESET 2'h0

`endif

// ### hdl/sbcl_pkg.sv
package sbcl_pkg;

  typedef enum logic [2:0] {
    SBCL_CMD_NOP = 3'b000,
    SBCL_CMD_ACT = 3'b001,
    SBCL_CMD_RD = 3'b010,
    SBCL_CMD_WR = 3'b011,
    SBCL_CMD_PRE = 3'b100,
    SBCL_CMD_BST = 3'b101,
    SBCL_CMD_REF = 3'b110,
    SBCL_CMD_LMR = 3'b111
  } sbcl_cmd_t;

  typedef enum logic [3:0] {
    SBCL_B_IDLE = 4'b0000,
    SBCL_B_ACTIVATING = 4'b0001,
    SBCL_B_ACTIVE = 4'b0010,
    SBCL_B_READ = 4'b0011,
    SBCL_B_WRITE = 4'b0100,
    SBCL_B_READ_AP = 4'b0101,
    SBCL_B_WRITE_AP = 4'b0110,
    SBCL_B_PRECHARGING = 4'b0111
  } sbcl_bank_t;

  typedef enum logic [1:0] {
    SBCL_D_NORMAL = 2'b00,
    SBCL_D_REFRESHING = 2'b01,
    SBCL_D_MODE_ACCESS = 2'b10,
    SBCL_D_PRECHARGE_ALL = 2'b11
  } sbcl_dev_t;

  // command pins as sampled on one rising edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
    logic [12:0] addr;
  } sbcl_pins_t;

  // decoded command handed to each bank tracker
  typedef struct packed {
    sbcl_cmd_t cmd;
    logic [1:0] bank;
    logic auto_pre;
    logic all_banks;
  } sbcl_dec_t;

endpackage

// ### hdl/sbcl_bank.sv
`timescale 1ns/1ps
`include "sbcl_map.svh"

module sbcl_bank
  import sbcl_pkg::*;
#(
  parameter int CW = 8
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_hit,
  input wire logic i_legal_en,
  input wire sbcl_dec_t i_dec,
  input wire logic i_bst_me,
  input wire logic i_force_idle,
  input wire logic [CW-1:0] i_t_rp,
  input wire logic [CW-1:0] i_t_rcd,
  input wire logic [CW-1:0] i_t_burst,
  output sbcl_bank_t o_state,
  output logic o_illegal
);

  typedef struct packed {
    sbcl_bank_t st;
    logic [CW-1:0] cnt;
  } sbcl_bk_state_t;

  sbcl_bk_state_t r;
  sbcl_bk_state_t next_r;
  logic [CW-1:0] dec_cnt;
  logic illegal;

  always_comb
  begin
    next_r = r;
    illegal = 1'b0;
    dec_cnt = (r.cnt != '0) ? r.cnt - 1'b1 : r.cnt;
    next_r.cnt = dec_cnt;
    // timed states expire on their own, commands not needed
    unique case (r.st)
      SBCL_B_ACTIVATING:
        if (dec_cnt == '0)
        begin
          next_r.st = SBCL_B_ACTIVE;
        end
      SBCL_B_PRECHARGING:
        if (dec_cnt == '0)
        begin
          next_r.st = SBCL_B_IDLE;
        end
      SBCL_B_READ, SBCL_B_WRITE:
        if (dec_cnt == '0)
        begin
          next_r.st = SBCL_B_ACTIVE;
        end
      SBCL_B_READ_AP, SBCL_B_WRITE_AP:
        if (dec_cnt == '0)
        begin
          next_r.st = SBCL_B_PRECHARGING;
          next_r.cnt = i_t_rp;
        end
      default:
      begin
      end
    endcase
    if (i_bst_me && r.st == SBCL_B_READ)
    begin
      next_r.st = SBCL_B_ACTIVE;
      next_r.cnt = '0;
    end
    if (i_force_idle)
    begin
      next_r.st = SBCL_B_IDLE;
      next_r.cnt = '0;
    end
    else if (i_hit && i_legal_en)
    begin
      unique case (i_dec.cmd)
        SBCL_CMD_ACT:
          if (r.st == SBCL_B_IDLE)
          begin
            next_r.st = SBCL_B_ACTIVATING;
            next_r.cnt = i_t_rcd;
          end
          else
          begin
            illegal = 1'b1;
          end
        SBCL_CMD_RD, SBCL_CMD_WR:
          // both auto precharge forms accepted
          if (r.st == SBCL_B_ACTIVE || r.st == SBCL_B_READ || r.st == SBCL_B_WRITE)
          begin
            next_r.cnt = i_t_burst;
            if (i_dec.cmd == SBCL_CMD_RD)
            begin
              next_r.st = i_dec.auto_pre ? SBCL_B_READ_AP : SBCL_B_READ;
            end
            else
            begin
              next_r.st = i_dec.auto_pre ? SBCL_B_WRITE_AP : SBCL_B_WRITE;
            end
          end
          else
          begin
            illegal = 1'b1;
          end
        SBCL_CMD_PRE:
          // precharge truncates a plain burst
          if (r.st == SBCL_B_ACTIVE || r.st == SBCL_B_READ || r.st == SBCL_B_WRITE
              || (i_dec.all_banks && r.st == SBCL_B_IDLE))
          begin
            next_r.st = SBCL_B_PRECHARGING;
            next_r.cnt = i_t_rp;
          end
          else
          begin
            illegal = 1'b1;
          end
        default:
        begin
        end
      endcase
    end
    if (next_r.st == SBCL_B_PRECHARGING && next_r.cnt == '0)
    begin
      next_r.st = SBCL_B_IDLE;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      r <= '{st: SBCL_B_IDLE, cnt: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_state = r.st;
  // same-edge verdict, so the top can veto the accept pulse of this very command
  assign o_illegal = illegal;

endmodule

// ### verification/sbcl_top_checker.sv
`timescale 1ns/1ps
module sbcl_top_checker
  import sbcl_pkg::*;
#(
  parameter int NBANK = 4,
  parameter int NBYTE = 2,
  parameter int T_RP = 3,
  parameter int T_RCD = 3,
  parameter int T_RFC = 8,
  parameter int T_MRD = 2
)
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_SRST,
  // inputs
  input wire sbcl_pins_t I_PINS,
  input wire logic I_CKE,
  input wire logic I_EXIT_DONE,
  input wire logic [8*NBYTE-1:0] I_WDATA,
  input wire logic [NBYTE-1:0] I_WRITE_BYTE_MASK,
  input wire logic I_WDATA_VALID,
  // outputs
  input wire logic [4*NBANK-1:0] O_BANK_STATE,
  input wire logic [1:0] O_DEV_STATE,
  input wire logic O_CMD_ACCEPTED,
  input wire logic O_CMD_ILLEGAL,
  input wire logic [8*NBYTE-1:0] O_ARRAY_WDATA,
  input wire logic [NBYTE-1:0] O_ARRAY_BYTE_WE
);
  localparam int RP1 = T_RP - 1;
  localparam int RCD1 = T_RCD - 1;
  localparam int RFC1 = T_RFC - 1;
  localparam int MRD1 = T_MRD - 1;
  logic cke_prev;
  logic go;
  logic on0;
  logic norm;
  logic hit0;
  logic [2:0] op;
  logic [3:0] b0;
  assign go = cke_prev & I_CKE & I_EXIT_DONE & ~I_PINS.cs_n;
  assign op = {I_PINS.ras_n, I_PINS.cas_n, I_PINS.we_n};
  assign b0 = O_BANK_STATE[3:0];
  assign on0 = go & (I_PINS.bank == 2'h0);
  assign norm = O_DEV_STATE == SBCL_D_NORMAL;
  // row commands aimed at bank 0 alone; precharge-all is a device command
  assign hit0 = on0 & (op == 3'h3 | op == 3'h5 | op == 3'h4 | (op == 3'h2 & ~I_PINS.addr[10]));
  always_ff @(posedge I_MCLK)
    cke_prev <= I_SRST ? 1'b0 : I_CKE;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  ////////////////////////////////////////////////////////////
  chk_desel_quiet: assert property (I_PINS.cs_n |=> !O_CMD_ACCEPTED && !O_CMD_ILLEGAL)
    else $error("deselect produced a command pulse");
  chk_cke_gate: assert property (!(cke_prev && I_CKE) |=> !O_CMD_ACCEPTED)
    else $error("command accepted without clock enable");
  chk_act_timing: assert property (hit0 && op == 3'h3 && b0 == SBCL_B_IDLE && norm
    |=> O_CMD_ACCEPTED && b0 == SBCL_B_ACTIVATING ##RCD1 b0 == SBCL_B_ACTIVE)
    else $error("activate timing wrong");
  chk_busy_bank: assert property (hit0 && (b0 == SBCL_B_ACTIVATING || b0 == SBCL_B_READ_AP
    || b0 == SBCL_B_WRITE_AP || b0 == SBCL_B_PRECHARGING) |=> O_CMD_ILLEGAL)
    else $error("busy bank took a command");
  chk_rd_entry: assert property (hit0 && op == 3'h5 && b0 == SBCL_B_ACTIVE && norm
    |=> b0 == ($past(I_PINS.addr[10]) ? SBCL_B_READ_AP : SBCL_B_READ))
    else $error("read entry state wrong");
  chk_pre_trunc: assert property (hit0 && op == 3'h2 && norm && (b0 == SBCL_B_ACTIVE
    || b0 == SBCL_B_READ || b0 == SBCL_B_WRITE) |=> b0 == SBCL_B_PRECHARGING ##RP1 b0 == SBCL_B_IDLE)
    else $error("precharge timing wrong");
  chk_refresh_time: assert property (go && op == 3'h1 && norm && ~|O_BANK_STATE
    |=> O_DEV_STATE == SBCL_D_REFRESHING ##RFC1 O_DEV_STATE == SBCL_D_NORMAL)
    else $error("refresh timing wrong");
  chk_mode_time: assert property (go && op == 3'h0 && norm && ~|O_BANK_STATE
    |=> O_DEV_STATE == SBCL_D_MODE_ACCESS ##MRD1 O_DEV_STATE == SBCL_D_NORMAL)
    else $error("mode load timing wrong");
  chk_preall_time: assert property (go && op == 3'h2 && I_PINS.addr[10] && norm
    |=> O_DEV_STATE == SBCL_D_PRECHARGE_ALL ##RP1 O_DEV_STATE == SBCL_D_NORMAL && ~|O_BANK_STATE)
    else $error("precharge all timing wrong");
  chk_dev_busy: assert property (go && !norm && op != 3'h7 |=> O_CMD_ILLEGAL)
    else $error("busy device took a command");
  chk_byte_mask: assert property (I_WDATA_VALID |=> O_ARRAY_BYTE_WE == ~$past(I_WRITE_BYTE_MASK)
    && O_ARRAY_WDATA == $past(I_WDATA))
    else $error("masked write wrong");
endmodule
bind sbcl_top sbcl_top_checker #(.NBANK(NBANK), .NBYTE(NBYTE), .T_RP(T_RP), .T_RCD(T_RCD), .T_RFC(T_RFC),
  .T_MRD(T_MRD)) u_chk (.I_MCLK, .I_SRST, .I_PINS, .I_CKE, .I_EXIT_DONE, .I_WDATA, .I_WRITE_BYTE_MASK,
  .I_WDATA_VALID, .O_BANK_STATE, .O_DEV_STATE, .O_CMD_ACCEPTED, .O_CMD_ILLEGAL, .O_ARRAY_WDATA, .O_ARRAY_BYTE_WE);

// ### verification/sbcl_ctrl_model.sv
`timescale 1ns/1ps
module sbcl_ctrl_model
  import sbcl_pkg::*;
(
  // clock
  input wire logic i_clk,
  // request from the bench
  input wire logic i_go,
  input wire sbcl_cmd_t i_cmd,
  input wire logic [1:0] i_bank,
  input wire logic i_a10,
  // pins toward the device
  output sbcl_pins_t o_pins
);
  logic [2:0] junk = 3'h5;
  logic [2:0] code;
  // idle strobes churn so a deselected device cannot lean on stale levels
  always_ff @(posedge i_clk)
    junk <= junk + 3'h3;
  always_comb
  begin
    // during a request only the listed command codes, or nop for any other, leave the model
    case (i_cmd)
      SBCL_CMD_ACT: code = 3'h3;
      SBCL_CMD_RD: code = 3'h5;
      SBCL_CMD_WR: code = 3'h4;
      SBCL_CMD_PRE: code = 3'h2;
      SBCL_CMD_BST: code = 3'h6;
      SBCL_CMD_REF: code = 3'h1;
      SBCL_CMD_LMR: code = 3'h0;
      default: code = 3'h7;
    endcase
    // between requests only deselect is sent
    o_pins.cs_n = ~i_go;
    {o_pins.ras_n, o_pins.cas_n, o_pins.we_n} = i_go ? code : junk;
    o_pins.bank = i_go ? i_bank : junk[1:0];
    o_pins.addr = i_go ? {2'h0, i_a10, 10'h000} : {13{junk[0]}};
  end
endmodule

// ### verification/sdram_bank_command_legality_test.sv
`timescale 1ns/1ps
module sdram_bank_command_legality_test
  import sbcl_pkg::*;
;
  logic I_MCLK = 1'b0;
  logic I_SRST = 1'b1;
  logic I_CKE = 1'b1;
  logic exit_done = 1'b1;
  logic go = 1'b0;
  sbcl_cmd_t cmd = SBCL_CMD_NOP;
  logic [1:0] bank = 2'h0;
  logic a10 = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] mask = 2'h0;
  logic valid = 1'b0;
  sbcl_pins_t pins;
  logic [15:0] bst;
  logic [1:0] dst;
  logic acc;
  logic ill;
  logic [15:0] awd;
  logic [1:0] awe;
  int failures = 0;
  int n_compared = 0;
  always #10 I_MCLK = ~I_MCLK;
  sbcl_ctrl_model u_ctrl (.i_clk(I_MCLK), .i_go(go), .i_cmd(cmd), .i_bank(bank), .i_a10(a10), .o_pins(pins));
  sbcl_top #(.T_RP(3), .T_RCD(3), .T_RFC(8), .T_MRD(2), .T_BURST(4)) dut (.I_MCLK(I_MCLK), .I_SRST(I_SRST),
    .I_PINS(pins), .I_CKE(I_CKE), .I_EXIT_DONE(exit_done), .I_WDATA(wdata), .I_WRITE_BYTE_MASK(mask),
    .I_WDATA_VALID(valid), .O_BANK_STATE(bst), .O_DEV_STATE(dst), .O_CMD_ACCEPTED(acc), .O_CMD_ILLEGAL(ill),
    .O_ARRAY_WDATA(awd), .O_ARRAY_BYTE_WE(awe));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [3:0] st(input int b);
    return bst[4*b +: 4];
  endfunction
  // one request, then the bench sits mid-cycle where its answer is settled
  task automatic issue(input sbcl_cmd_t c, input logic [1:0] b, input logic a);
    @(posedge I_MCLK);
    go <= 1'b1;
    cmd <= c;
    bank <= b;
    a10 <= a;
    @(posedge I_MCLK);
    go <= 1'b0;
    @(negedge I_MCLK);
  endtask
  task automatic pulse(input logic a, input logic i);
    check({acc, ill}, {a, i});
  endtask
  task automatic t_quiet();
    repeat (8)
    begin
      @(negedge I_MCLK);
      check({acc, ill, bst}, 18'h0_0000);
    end
    issue(SBCL_CMD_NOP, 2'h0, 1'b0);
    pulse(1'b0, 1'b0);
    issue(SBCL_CMD_BST, 2'h0, 1'b0);
    pulse(1'b0, 1'b1);
    @(posedge I_MCLK);
    I_CKE <= 1'b0;
    issue(SBCL_CMD_ACT, 2'h0, 1'b0);
    check({acc, st(0)}, 5'h00);
    @(posedge I_MCLK);
    I_CKE <= 1'b1;
    exit_done <= 1'b0;
    issue(SBCL_CMD_ACT, 2'h0, 1'b0);
    check({acc, ill, st(0)}, 6'h00);
    @(posedge I_MCLK);
    exit_done <= 1'b1;
  endtask
  task automatic t_bank();
    issue(SBCL_CMD_ACT, 2'h0, 1'b0);
    check({acc, st(0)}, {1'b1, SBCL_B_ACTIVATING});
    // lands on the last activating edge, so it must be refused
    issue(SBCL_CMD_RD, 2'h0, 1'b0);
    check({ill, st(0)}, {1'b1, SBCL_B_ACTIVE});
    issue(SBCL_CMD_RD, 2'h0, 1'b0);
    check({acc, st(0)}, {1'b1, SBCL_B_READ});
    issue(SBCL_CMD_BST, 2'h3, 1'b0);
    check({acc, st(0)}, {1'b1, SBCL_B_ACTIVE});
    issue(SBCL_CMD_WR, 2'h0, 1'b1); // write with auto precharge, issued after the read was terminated
    check({acc, st(0)}, {1'b1, SBCL_B_WRITE_AP});
    issue(SBCL_CMD_ACT, 2'h0, 1'b0);
    pulse(1'b0, 1'b1);
    issue(SBCL_CMD_ACT, 2'h1, 1'b0);
    check({acc, st(1)}, {1'b1, SBCL_B_ACTIVATING});
    repeat (20)
      if (st(0) !== SBCL_B_IDLE)
        @(negedge I_MCLK);
    check(st(0), SBCL_B_IDLE);
  endtask
  task automatic t_pre();
    issue(SBCL_CMD_ACT, 2'h0, 1'b0);
    repeat (2) @(negedge I_MCLK);
    issue(SBCL_CMD_RD, 2'h0, 1'b0);
    issue(SBCL_CMD_PRE, 2'h0, 1'b0);
    check({acc, st(0)}, {1'b1, SBCL_B_PRECHARGING});
    issue(SBCL_CMD_ACT, 2'h0, 1'b0);
    check({ill, st(0)}, {1'b1, SBCL_B_IDLE});
  endtask
  task automatic dev_op(input sbcl_cmd_t c, input logic a, input logic [1:0] code, input int t);
    issue(c, 2'h2, a);
    check({acc, dst}, {1'b1, code});
    issue(SBCL_CMD_ACT, 2'h2, 1'b0);
    pulse(t <= 2, t > 2);
    repeat ((t > 3) ? t - 3 : 0) @(negedge I_MCLK);
    // a short mode access ends in time for the activate to land on bank 2
    check({dst, bst}, (t > 2) ? 18'h0_0000 : 18'h0_0100);
    if (t <= 2)
    begin
      // let bank 2 reach row active before precharge-all returns every bank to idle
      @(negedge I_MCLK);
      issue(SBCL_CMD_PRE, 2'h2, 1'b1);
    end
  endtask
  task automatic t_dev();
    // bank 1 still open, so refresh has to be turned away
    issue(SBCL_CMD_REF, 2'h0, 1'b0);
    check({ill, dst}, 3'h4);
    dev_op(SBCL_CMD_PRE, 1'b1, SBCL_D_PRECHARGE_ALL, 3);
    dev_op(SBCL_CMD_REF, 1'b0, SBCL_D_REFRESHING, 8);
    dev_op(SBCL_CMD_LMR, 1'b0, SBCL_D_MODE_ACCESS, 2);
  endtask
  task automatic t_mask();
    for (int m = 0; m < 4; m++)
    begin
      @(posedge I_MCLK);
      wdata <= 16'hA5C3 ^ 16'(m);
      mask <= 2'(m);
      valid <= 1'b1;
      @(posedge I_MCLK);
      @(negedge I_MCLK);
      check({awe, awd}, {~2'(m), 16'hA5C3 ^ 16'(m)});
    end
  endtask
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge I_MCLK);
    failures++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge I_MCLK);
    I_SRST <= 1'b0;
    t_quiet();
    t_bank();
    t_pre();
    t_dev();
    t_mask();
    conclude();
  end
endmodule
